// ===== core/dspcc_pkg.sv
// Shared constants for the DSP core control register block
package dspcc_pkg;

    // Clock and rate scaling
    localparam int MCLK_KHZ = 20000;
    localparam int RATE_UNITS_PER_MHZ = 64;
    localparam logic [15:0] SRC_RATE_UNITS =
        16'(MCLK_KHZ * RATE_UNITS_PER_MHZ / 1000);

    // Register map, byte addresses
    localparam logic [31:0] SUBSYS_BASE = 32'h0020_0000;
    localparam logic [31:0] OFF_RATE_REQ = 32'h00b8_0000;
    localparam logic [31:0] OFF_RATE_ACT = 32'h00b8_0008;
    localparam logic [31:0] OFF_SUBSYS_RST = 32'h00b8_0010;
    localparam logic [31:0] OFF_ARB_RESYNC = 32'h00b8_0050;
    localparam logic [31:0] OFF_CORE_CTRL = 32'h00bc_1000;
    localparam logic [31:0] OFF_ARB_SELECT = 32'h00bc_5a00;

    // Field positions
    localparam int CORE_RUN_BIT = 0;
    localparam int CORE_RESET_BIT = 9;
    localparam int SUBSYS_RST_BIT = 0;
    localparam int ARB_RESYNC_BIT = 0;

    // Reset values
    localparam logic [15:0] RATE_REQ_RESET = 16'h0000;
    localparam logic [7:0] ARB_SELECT_RESET = 8'h00;
    localparam logic CORE_RUN_RESET = 1'b0;

    // Core starts fetching here after every reset
    localparam logic [31:0] PM_BASE_ADDR = 32'h0000_0000;

    // Stream arbiter masters and interrupt groups
    localparam int ARB_MASTERS = 8;
    localparam int ERR_EVENTS = 7;
    localparam int GP_IRQS = 4;
    localparam int PROF_EVENTS = 2;

endpackage

// ===== core/dspcc_clk_div.sv
// Integer divider making the DSP clock enable pulse from mclk
`timescale 1ns/1ps
`default_nettype none
module dspcc_clk_div (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic restart,
    input wire logic [15:0] divisor,
    // Output
    output logic tick
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic tick_next;

    always_comb begin
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        // Divisor of zero means no clock at all
        if (restart || divisor == 16'h0000) begin
            cnt_next = 16'h0000;
        end else if (cnt_reg >= divisor - 16'h0001) begin
            cnt_next = 16'h0000;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 16'h0000;
            tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick <= tick_next;
        end
    end
endmodule
`default_nettype wire

// ===== core/dspcc_regs.sv
// DSP core control and status registers with reset and clock control
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Registers decoded at subsystem base plus offset
// - Sixteen-bit rate request, 1/64 MHz units
// - DSP clock is integer division of source
// - Achieved rate readable, valid while core enabled
// - Subsystem reset clears core, arbiters, NMI, watchdog
// - Resync resets only selected arbiter masters
// - Eight select bits, one per master
// - Bit nine pulse resets core alone
// - Bit zero enables firmware execution
// - Error and event lines to interrupt controller
// - Firmware drives general-purpose interrupt lines
// - Non-maskable interrupt to core for failures
// - Core held reset while disabled, boots at base
// - Register access needs no DSP clock
module dspcc_regs
    import dspcc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Host register port
    input wire logic wr_en,
    input wire logic [31:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic rd_en,
    input wire logic [31:0] rd_addr,
    output logic [31:0] rd_data,
    output logic rd_valid,
    // Core and subsystem status inputs
    input wire logic [ARB_MASTERS-1:0] arb_master_active,
    input wire logic [ERR_EVENTS-1:0] core_err_events,
    input wire logic [GP_IRQS-1:0] fw_gp_irq,
    input wire logic [PROF_EVENTS-1:0] prof_done,
    input wire logic nmi_request,
    // Core control outputs
    output logic core_run,
    output logic core_reset,
    output logic [31:0] core_boot_addr,
    output logic core_nmi,
    output logic dsp_clk_en,
    // Subsystem reset outputs
    output logic [ARB_MASTERS-1:0] arb_reset,
    output logic nmi_cfg_reset,
    output logic wdt_reset,
    // Device interrupt controller lines
    output logic [ERR_EVENTS-1:0] irq_err,
    output logic [GP_IRQS-1:0] irq_gp,
    output logic [PROF_EVENTS-1:0] irq_prof
);
    ////////////////////////////////////////////////////////////////////
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    logic [15:0] rate_req_reg, rate_req_next;
    logic [15:0] rate_act_reg, rate_act_next;
    logic [7:0] arb_select_reg, arb_select_next;
    logic core_run_reg, core_run_next;
    logic [31:0] rd_data_next;
    logic rd_valid_next;
    logic wr_req, wr_soft, wr_arb, wr_core, wr_sel;
    logic soft_pulse, resync_pulse, core_pulse;
    logic [15:0] div_n;

    // Full address compare: base plus offset
    assign wr_req = wr_en && wr_addr == SUBSYS_BASE + OFF_RATE_REQ;
    assign wr_soft = wr_en && wr_addr == SUBSYS_BASE + OFF_SUBSYS_RST;
    assign wr_arb = wr_en && wr_addr == SUBSYS_BASE + OFF_ARB_RESYNC;
    assign wr_core = wr_en && wr_addr == SUBSYS_BASE + OFF_CORE_CTRL;
    assign wr_sel = wr_en && wr_addr == SUBSYS_BASE + OFF_ARB_SELECT;

    assign soft_pulse = wr_soft && wr_data[SUBSYS_RST_BIT];
    assign resync_pulse = wr_arb && wr_data[ARB_RESYNC_BIT];
    assign core_pulse = wr_core && wr_data[CORE_RESET_BIT];

    // Divide ratio; a request above the source just gets the source
    always_comb begin
        if (rate_req_reg == 16'h0000) begin
            div_n = 16'h0000;
        end else if (rate_req_reg >= SRC_RATE_UNITS) begin
            div_n = 16'h0001;
        end else begin
            div_n = SRC_RATE_UNITS / rate_req_reg;
        end
    end

    always_comb begin
        rate_req_next = rate_req_reg;
        arb_select_next = arb_select_reg;
        core_run_next = core_run_reg;
        if (wr_req) begin
            rate_req_next = wr_data[15:0];
        end
        if (wr_sel) begin
            arb_select_next = wr_data[ARB_MASTERS-1:0];
        end
        if (wr_core) begin
            core_run_next = wr_data[CORE_RUN_BIT];
        end
        // Soft reset overrides any other write in the same cycle
        if (soft_pulse) begin
            rate_req_next = RATE_REQ_RESET;
            arb_select_next = ARB_SELECT_RESET;
            core_run_next = CORE_RUN_RESET;
        end
        // Status only meaningful while the core runs
        if (core_run_reg && div_n != 16'h0000) begin
            rate_act_next = SRC_RATE_UNITS / div_n;
        end else begin
            rate_act_next = 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read side: action registers read as zero
    always_comb begin
        rd_data_next = 32'h0000_0000;
        rd_valid_next = rd_en;
        if (rd_en) begin
            if (rd_addr == SUBSYS_BASE + OFF_RATE_REQ) begin
                rd_data_next[15:0] = rate_req_reg;
            end else if (rd_addr == SUBSYS_BASE + OFF_RATE_ACT) begin
                rd_data_next[15:0] = rate_act_reg;
            end else if (rd_addr == SUBSYS_BASE + OFF_CORE_CTRL) begin
                rd_data_next[CORE_RUN_BIT] = core_run_reg;
            end else if (rd_addr == SUBSYS_BASE + OFF_ARB_SELECT) begin
                rd_data_next[ARB_MASTERS-1:0] = arb_select_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs toward the core and subsystem
    logic core_reset_next, core_nmi_next, tick, dsp_clk_en_next;
    logic [ARB_MASTERS-1:0] arb_reset_next;
    logic any_clock_user;

    always_comb begin
        // Held while disabled, plus one cycle per reset pulse
        core_reset_next = !core_run_next || core_pulse
            || soft_pulse;
        arb_reset_next = {ARB_MASTERS{soft_pulse}};
        if (resync_pulse) begin
            arb_reset_next = arb_reset_next | arb_select_reg;
        end
        core_nmi_next = nmi_request && !soft_pulse;
        // Clock only runs for a busy core or an active master
        any_clock_user = core_run_reg || (|arb_master_active);
        dsp_clk_en_next = tick && any_clock_user;
    end

    dspcc_clk_div dspcc_clk_div_i (
        .clk(mclk),
        .rst_n(rst_n_reg),
        .restart(soft_pulse),
        .divisor(div_n),
        .tick(tick)
    );

    always_ff @(posedge mclk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rate_req_reg <= RATE_REQ_RESET;
            rate_act_reg <= 16'h0000;
            arb_select_reg <= ARB_SELECT_RESET;
            core_run_reg <= CORE_RUN_RESET;
            rd_data <= 32'h0000_0000;
            rd_valid <= 1'b0;
            core_run <= 1'b0;
            core_reset <= 1'b1;
            core_boot_addr <= PM_BASE_ADDR;
            core_nmi <= 1'b0;
            dsp_clk_en <= 1'b0;
            arb_reset <= '0;
            nmi_cfg_reset <= 1'b0;
            wdt_reset <= 1'b0;
            irq_err <= '0;
            irq_gp <= '0;
            irq_prof <= '0;
        end else begin
            rate_req_reg <= rate_req_next;
            rate_act_reg <= rate_act_next;
            arb_select_reg <= arb_select_next;
            core_run_reg <= core_run_next;
            rd_data <= rd_data_next;
            rd_valid <= rd_valid_next;
            core_run <= core_run_next;
            core_reset <= core_reset_next;
            core_boot_addr <= PM_BASE_ADDR;
            core_nmi <= core_nmi_next;
            dsp_clk_en <= dsp_clk_en_next;
            arb_reset <= arb_reset_next;
            nmi_cfg_reset <= soft_pulse;
            wdt_reset <= soft_pulse;
            irq_err <= core_err_events;
            irq_gp <= fw_gp_irq;
            irq_prof <= prof_done;
        end
    end

    ////////////////////////////////////////////////////////////////////
    soft_clears_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        soft_pulse |=> rate_req_reg == RATE_REQ_RESET
            && arb_select_reg == ARB_SELECT_RESET && !core_run_reg
    ) else $error("soft reset left control fields set");

    soft_resets_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        soft_pulse |=> core_reset && wdt_reset && nmi_cfg_reset
            && arb_reset == {ARB_MASTERS{1'b1}}
    ) else $error("soft reset did not reach all parts");

    resync_mask_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        resync_pulse && !soft_pulse |=> arb_reset == $past(arb_select_reg)
    ) else $error("resync hit the wrong masters");

    arb_quiet_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        !resync_pulse && !soft_pulse |=> arb_reset == '0
    ) else $error("arbiter reset without request");

    core_pulse_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        core_pulse |=> core_reset && !wdt_reset
    ) else $error("core reset pulse not seen alone");

    run_hold_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        !core_run_reg && !wr_core |=> core_reset && !core_run
    ) else $error("core not held in reset while disabled");

    pulse_read_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        rd_en && (rd_addr == SUBSYS_BASE + OFF_SUBSYS_RST
            || rd_addr == SUBSYS_BASE + OFF_ARB_RESYNC)
        |=> rd_valid && rd_data == 32'h0000_0000
    ) else $error("action register read nonzero");

    req_store_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        wr_req ##1 (rd_en && rd_addr == SUBSYS_BASE + OFF_RATE_REQ)
        |=> rd_data[15:0] == $past(wr_data[15:0], 2)
    ) else $error("rate request not stored");

    act_idle_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        !core_run_reg |=> rate_act_reg == 16'h0000
    ) else $error("achieved rate shown while core off");

    clk_gate_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        dsp_clk_en |-> $past(core_run_reg || (|arb_master_active))
    ) else $error("DSP clock with no user");

    irq_pass_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        ##1 irq_err == $past(core_err_events)
            && irq_prof == $past(prof_done)
    ) else $error("error lines not forwarded");

    gp_irq_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        ##1 irq_gp == $past(fw_gp_irq)
    ) else $error("firmware interrupt lines not forwarded");

    nmi_fwd_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        nmi_request && !soft_pulse |=> core_nmi
    ) else $error("non-maskable interrupt not raised");

    unmapped_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        rd_en && rd_addr == OFF_CORE_CTRL |=> rd_data == 32'h0000_0000
    ) else $error("offset decoded without base");

    run_bit_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        wr_core && !soft_pulse |=> core_run == $past(wr_data[CORE_RUN_BIT])
    ) else $error("run enable not taken from bit zero");

    sel_store_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        wr_sel && !soft_pulse
        |=> arb_select_reg == $past(wr_data[ARB_MASTERS-1:0])
    ) else $error("master select not stored");

    nmi_soft_a: assert property (
        @(posedge mclk) disable iff (!rst_n_reg)
        soft_pulse |=> !core_nmi
    ) else $error("non-maskable interrupt through soft reset");

endmodule
`default_nettype wire

// ===== tb/dspcc_host_model.sv
// Host processor model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module dspcc_host_model (
    // Clock
    input wire logic mclk,
    // Register port
    output logic wr_en,
    output logic [31:0] wr_addr,
    output logic [31:0] wr_data,
    output logic rd_en,
    output logic [31:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_valid
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        wr_addr = 32'hffff_ffff;
        wr_data = 32'h0;
        rd_addr = 32'hffff_ffff;
    end

    ////////////////////////////////////////////////////////////////////////
    // Callers keep the request within the source and write it before enabling the core
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(negedge mclk);
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge mclk);
        wr_en = 1'b0;
        // Released lines must not keep a stale value
        wr_addr = ~a;
        wr_data = ~d;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(negedge mclk);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge mclk);
        rd_en = 1'b0;
        rd_addr = ~a;
        d = 32'hxxxx_xxxx;
        for (int n = 0; n < 3; n++) begin
            if (rd_valid === 1'b1) begin
                d = rd_data;
                break;
            end
            @(negedge mclk);
        end
    endtask
endmodule
`default_nettype wire

// ===== tb/dspcc_regs_tb_top.sv
// Self-checking bench for the DSP core control registers
`timescale 1ns/1ps
`default_nettype none
module dspcc_regs_tb_top;
    import dspcc_pkg::*;
    localparam logic [31:0] A_REQ = SUBSYS_BASE + OFF_RATE_REQ;
    localparam logic [31:0] A_ACT = SUBSYS_BASE + OFF_RATE_ACT;
    localparam logic [31:0] A_RST = SUBSYS_BASE + OFF_SUBSYS_RST;
    localparam logic [31:0] A_RSY = SUBSYS_BASE + OFF_ARB_RESYNC;
    localparam logic [31:0] A_CTL = SUBSYS_BASE + OFF_CORE_CTRL;
    localparam logic [31:0] A_SEL = SUBSYS_BASE + OFF_ARB_SELECT;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic wr_en, rd_en, rd_valid, nmi_request = 1'b0;
    logic [31:0] wr_addr, wr_data, rd_addr, rd_data, core_boot_addr;
    logic [7:0] arb_master_active = 8'h00;
    logic [6:0] core_err_events = 7'h00;
    logic [3:0] fw_gp_irq = 4'h0;
    logic [1:0] prof_done = 2'h0;
    logic core_run, core_reset, core_nmi, dsp_clk_en;
    logic [7:0] arb_reset;
    logic nmi_cfg_reset, wdt_reset;
    logic [6:0] irq_err;
    logic [3:0] irq_gp;
    logic [1:0] irq_prof;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    dspcc_regs dspcc_regs_i (
        .mclk(mclk), .reset_n(reset_n), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid),
        .arb_master_active(arb_master_active),
        .core_err_events(core_err_events), .fw_gp_irq(fw_gp_irq),
        .prof_done(prof_done), .nmi_request(nmi_request),
        .core_run(core_run), .core_reset(core_reset),
        .core_boot_addr(core_boot_addr), .core_nmi(core_nmi),
        .dsp_clk_en(dsp_clk_en), .arb_reset(arb_reset),
        .nmi_cfg_reset(nmi_cfg_reset), .wdt_reset(wdt_reset),
        .irq_err(irq_err), .irq_gp(irq_gp), .irq_prof(irq_prof)
    );
    dspcc_host_model dspcc_host_model_i (
        .mclk(mclk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid)
    );

    always #25 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        dspcc_host_model_i.rd(a, v);
        check(v, exp);
    endtask

    // Pulses of the DSP clock enable over a window
    task automatic pulses(input int win, input int exp);
        int n;
        n = 0;
        repeat (win) begin
            @(negedge mclk);
            n += int'(dsp_clk_en);
        end
        check(32'(n), 32'(exp));
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic t_map;
        rc(A_REQ, 32'h0);
        rc(A_SEL, 32'h0);
        rc(A_CTL, 32'h0);
        rc(A_ACT, 32'h0);
        check(32'(core_reset), 32'h1);
        check(core_boot_addr, PM_BASE_ADDR);
        dspcc_host_model_i.wr(A_REQ, 32'hbeef_0280);
        rc(A_REQ, 32'h0000_0280);
        dspcc_host_model_i.wr(A_ACT, 32'h0000_1234);
        rc(A_ACT, 32'h0);
        rc(A_REQ + 32'h4, 32'h0);
        rc(OFF_CORE_CTRL, 32'h0);
        rc(A_RST, 32'h0);
        $display("test map done");
    endtask

    // Request of 640 units halves the 1280-unit source
    task automatic t_run;
        pulses(40, 0);
        dspcc_host_model_i.wr(A_CTL, 32'h1);
        check({30'h0, core_run, core_reset}, 32'h2);
        pulses(40, 40 / int'(SRC_RATE_UNITS / 16'd640));
        rc(A_ACT, 32'(SRC_RATE_UNITS / (SRC_RATE_UNITS / 16'd640)));
        dspcc_host_model_i.wr(A_CTL, 32'h201);
        check({30'h0, core_run, core_reset}, 32'h3);
        @(negedge mclk);
        check({30'h0, core_run, core_reset}, 32'h2);
        rc(A_CTL, 32'h1);
        dspcc_host_model_i.wr(A_CTL, 32'h0);
        check(32'(core_reset), 32'h1);
        arb_master_active = 8'h01;
        pulses(40, 20);
        rc(A_ACT, 32'h0);
        arb_master_active = 8'h00;
        $display("test run done");
    endtask

    task automatic t_resync;
        dspcc_host_model_i.wr(A_SEL, 32'hffff_ffa5);
        rc(A_SEL, 32'h0000_00a5);
        dspcc_host_model_i.wr(A_RSY, 32'h1);
        check(32'(arb_reset), 32'ha5);
        @(negedge mclk);
        check(32'(arb_reset), 32'h0);
        $display("test resync done");
    endtask

    task automatic t_soft;
        dspcc_host_model_i.wr(A_CTL, 32'h1);
        dspcc_host_model_i.wr(A_RST, 32'h1);
        check({arb_reset, 5'h0, wdt_reset, nmi_cfg_reset, core_reset},
              32'hff07);
        check(32'(core_run), 32'h0);
        @(negedge mclk);
        check({arb_reset, 5'h0, wdt_reset, nmi_cfg_reset, core_reset},
              32'h0001);
        rc(A_REQ, 32'h0);
        rc(A_SEL, 32'h0);
        rc(A_CTL, 32'h0);
        $display("test soft reset done");
    endtask

    task automatic t_irq;
        for (int k = 0; k < 2; k++) begin
            core_err_events = k ? 7'h2a : 7'h55;
            fw_gp_irq = k ? 4'h5 : 4'ha;
            prof_done = k ? 2'h1 : 2'h2;
            nmi_request = k ? 1'b0 : 1'b1;
            @(negedge mclk);
            check(32'(irq_err), 32'(core_err_events));
            check(32'(irq_gp), 32'(fw_gp_irq));
            check(32'(irq_prof), 32'(prof_done));
            check(32'(core_nmi), 32'(nmi_request));
        end
        $display("test interrupts done");
    endtask

    // Mid-run reset; inputs idle so forwarded lines stay quiet
    task automatic t_reset;
        dspcc_host_model_i.wr(A_REQ, 32'h0000_0140);
        dspcc_host_model_i.wr(A_CTL, 32'h1);
        core_err_events = 7'h00;
        fw_gp_irq = 4'h0;
        prof_done = 2'h0;
        reset_n = 1'b0;
        #1;
        check({30'h0, core_run, core_reset}, 32'h1);
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        check(32'(irq_err), 32'h0);
        rc(A_REQ, 32'(RATE_REQ_RESET));
        rc(A_CTL, 32'h0);
        $display("test reset done");
    endtask

    initial begin
        repeat (8) @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        t_map();
        t_run();
        t_resync();
        t_soft();
        t_irq();
        t_reset();
        finish_test();
    end
endmodule
`default_nettype wire
